// [binary_command_frame_handler_tb.sv]
// Self-checking bench for frame_handler with host and executor models.
// Assumes host_model.sv and the design files are compiled first.
`timescale 1ns/1ns
module binary_command_frame_handler_tb;
  import frame_pkg::*;
  localparam logic [7:0] MA = 8'h3c;
  localparam logic [7:0] RA = 8'h7e;
  logic       clk_in, rst_b_in, can_mode_in, rx_valid_in, rx_break_in, tx_ready_in;
  logic       tx_valid_out, tx_oe_b_out, exec_req_out, exec_done_in, tx_last_out;
  logic [7:0] rx_data_in, tx_data_out, last_byte;
  int         n_last;
  cmd_core_s  exec_cmd_out, got_cmd;
  result_s    exec_result_in;
  int         err_count, comparisons, cycles, n_exec;
  logic [7:0] st_tab[7] = '{8'h64, 8'h65, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06};
  frame_handler #(.MODULE_ADDR(MA), .REPLY_ADDR(RA)) dut_u (
    .clk_in(clk_in), .rst_b_in(rst_b_in), .can_mode_in(can_mode_in),
    .rx_data_in(rx_data_in), .rx_valid_in(rx_valid_in), .rx_break_in(rx_break_in),
    .tx_data_out(tx_data_out), .tx_valid_out(tx_valid_out), .tx_ready_in(tx_ready_in),
    .tx_oe_b_out(tx_oe_b_out), .tx_last_out(tx_last_out), .exec_cmd_out(exec_cmd_out),
    .exec_req_out(exec_req_out), .exec_done_in(exec_done_in), .exec_result_in(exec_result_in));
  host_model host_u (
    .clk_in(clk_in), .tx_data_in(tx_data_out), .tx_valid_in(tx_valid_out),
    .rx_data_out(rx_data_in), .rx_valid_out(rx_valid_in), .rx_break_out(rx_break_in),
    .tx_ready_out(tx_ready_in));
  initial begin
    clk_in = 1'b0;
    forever #4 clk_in = ~clk_in;
  end
  // ==========================================
  // Checking and closing
  task automatic chk(input string name, input logic [63:0] seen, input logic [63:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic end_sim();
    $display("errors %0d comparisons %0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      end_sim();
    end
    if (tx_valid_out === 1'b1 && tx_ready_in === 1'b1) chk("oe in send", tx_oe_b_out, 0);
    if (tx_valid_out === 1'b1 && tx_ready_in === 1'b1 && tx_last_out === 1'b1) begin
      n_last++;
      last_byte = tx_data_out;
    end
  end
  // ==========================================
  // Executor: answers each request after 0 to 3 cycles
  initial begin
    exec_done_in = 1'b0;
    forever begin
      @(posedge clk_in);
      #1;
      if (exec_req_out === 1'b1) begin
        got_cmd = exec_cmd_out;
        n_exec++;
        repeat ($urandom_range(3)) begin
          @(posedge clk_in);
          #1;
        end
        exec_done_in = 1'b1;
        @(posedge clk_in);
        #1 exec_done_in = 1'b0;
      end
    end
  end
  // ==========================================
  // One command, its reference reply, and the comparison
  task automatic run(input bit can, input logic [7:0] addr, input bit bad, input logic [7:0] st);
    byte unsigned f[$], e[$];
    cmd_core_s    c;
    result_s      r;
    logic [7:0]   s;
    int           len;
    bit           hit;
    c = {8'($urandom), 8'($urandom), 8'($urandom), 32'($urandom)};
    hit = can || addr == MA;
    exec_result_in = {st, 32'($urandom)};
    r = bad ? {8'h01, 32'h0} : exec_result_in;
    can_mode_in = can;
    if (!can) f.push_back(addr);
    for (int i = 0; i < 7; i++) f.push_back(c[55-8*i -: 8]);
    s = 8'h00;
    foreach (f[i]) s += f[i];
    if (!can) f.push_back(s + 8'(bad));
    if (!can) e = '{RA, MA};
    e.push_back(r.status);
    e.push_back(c.cmd);
    for (int i = 0; i < 4; i++) e.push_back(r.value[31-8*i -: 8]);
    s = 8'h00;
    foreach (e[i]) s += e[i];
    if (!can) e.push_back(s);
    len = hit ? e.size() : 0;
    n_exec = 0;
    n_last = 0;
    host_u.got.delete();
    host_u.send(f);
    for (int i = 0; i < 300; i++) begin
      @(posedge clk_in);
      #1;
      if (len == 0) chk("oe idle", tx_oe_b_out, 1);
      if (i >= 20 && host_u.got.size() == len && tx_oe_b_out === 1'b1) break;
    end
    chk("reply length", host_u.got.size(), len);
    for (int i = 0; i < len; i++) chk("reply byte", host_u.got[i], e[i]);
    chk("exec count", n_exec, hit && !bad);
    chk("last flag", n_last, hit);
    if (hit) chk("last byte", last_byte, e[len-1]);
    if (n_exec == 1) chk("exec cmd", got_cmd, c);
  endtask
  // ==========================================
  // Main sequence
  initial begin
    void'($urandom(32'h58f2));
    rst_b_in = 1'b0;
    can_mode_in = 1'b0;
    exec_result_in = '0;
    repeat (4) @(posedge clk_in);
    #1 rst_b_in = 1'b1;
    // A foreign frame first, so the addressed frames after it catch a stale sum
    run(0, MA ^ 8'h01, 0, 8'h64);
    for (int i = 0; i < 14; i++) begin
      host_u.slow = i[0];
      run(0, MA, 0, st_tab[i%7]);
    end
    run(0, MA, 1, 8'h64);
    host_u.send('{MA, 8'h11, 8'h22, 8'h33});
    host_u.brk();
    run(0, MA, 0, 8'h64);
    for (int i = 0; i < 7; i++) run(1, 8'h00, 0, st_tab[i]);
    run(0, MA, 0, 8'h65);
    end_sim();
  end
endmodule

// [byte_skid.sv]
// Two-entry byte buffer with valid/ready on both sides.
// Assumes a single clock and synchronous active-low reset.
`timescale 1ns/1ns
module byte_skid #(
  parameter int WIDTH = 8
) (
  input  wire logic             clk_in,
  input  wire logic             rst_b_in,
  input  wire logic [WIDTH-1:0] in_data_in,
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  output logic [WIDTH-1:0]      out_data_out,
  output logic                  out_valid_out,
  input  wire logic             out_ready_in
);
  // ==========================================
  // Storage
  logic [WIDTH-1:0] mem_reg [2];
  logic [WIDTH-1:0] mem_next [2];
  logic [1:0]       count_reg;
  logic [1:0]       count_next;
  logic             push;
  logic             pop;

  assign in_ready_out  = (count_reg != 2'h2);
  assign out_valid_out = (count_reg != 2'h0);
  assign out_data_out  = mem_reg[0];
  assign push = in_valid_in && in_ready_out;
  assign pop  = out_valid_out && out_ready_in;

  always_comb begin
    mem_next[0] = mem_reg[0];
    mem_next[1] = mem_reg[1];
    count_next  = count_reg;
    if (pop) begin
      mem_next[0] = mem_reg[1];
    end
    if (push) begin
      if (count_reg == 2'h0 || (count_reg == 2'h1 && pop)) begin
        mem_next[0] = in_data_in;
      end else if (pop) begin
        mem_next[1] = in_data_in;
      end else begin
        mem_next[count_reg[0]] = in_data_in;
      end
    end
    count_next = count_reg + {1'b0, push} - {1'b0, pop};
  end

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      mem_reg[0] <= '0;
      mem_reg[1] <= '0;
      count_reg  <= 2'h0;
    end else begin
      mem_reg[0] <= mem_next[0];
      mem_reg[1] <= mem_next[1];
      count_reg  <= count_next;
    end
  end

  a_no_overflow: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    count_reg != 2'h3)
    else $error("buffer accepts while full");
endmodule

// [frame_defs.svh]
// Constants for the binary command frame handler.
// Assumes inclusion by the package and the design modules only.
`ifndef FRAME_DEFS_SVH
`define FRAME_DEFS_SVH
`define CMD_LEN_SERIAL   4'h9
`define CMD_LEN_CAN      4'h7
`define CMD_ADDR_IDX     4'h0
`define CMD_CKSUM_IDX    4'h8
`define CORE_OFS_SERIAL  4'h1
`define CORE_OFS_CAN     4'h0
`define RPL_LAST_CAN     4'h5
`define ST_OK            8'h64
`define ST_STORED        8'h65
`define ST_BAD_CKSUM     8'h01
`define ST_BAD_CMD       8'h02
`define ST_BAD_TYPE      8'h03
`define ST_BAD_VALUE     8'h04
`define ST_LOCKED        8'h05
`define ST_NOT_AVAIL     8'h06
`endif

// [frame_handler.sv]
// Binary command frame receiver, executor handshake and reply sender.
// Assumes a byte-wide receive stream, an external command executor and a
// half-duplex line driver controlled by tx_oe_b_out.
`timescale 1ns/1ns
`include "frame_defs.svh"
// What this block does
// [RQ1] The host sends its next command only after it has got the reply to the previous one.
// [RQ2] The block never transmits unless it has first received a command addressed to it.
// [RQ3] The line driver stays in receive mode except while a reply frame is being sent.
// [RQ4] The command core is seven bytes: command, type, motor or bank, and a four-byte value.
// [RQ5] On byte links the core is wrapped by an address byte and a checksum byte, nine bytes in all.
// [RQ6] Command bytes arrive as address, command, type, bank, value most significant first, checksum.
// [RQ7] The command checksum is the 8-bit wrapping sum of all earlier bytes including the address.
// [RQ8] Every received command gets exactly one reply frame.
// [RQ9] Reply bytes are reply address, module address, status, command, value most significant first, checksum.
// [RQ10] The reply checksum is the 8-bit wrapping sum of all other reply bytes.
// [RQ11] In CAN mode address and checksum bytes are absent from both command and reply.
// [RQ12] Status 100 means success, 1 to 6 mean checksum, command, type, value, lock and availability errors.
// [RQ13] A command stored into program memory is answered with status 101.
// [RQ14] A command with a bad checksum is not executed and is answered with the checksum error status.
module frame_handler
  import frame_pkg::*;
#(
  parameter logic [7:0] MODULE_ADDR = 8'h01,
  parameter logic [7:0] REPLY_ADDR  = 8'h02
) (
  input  wire logic        clk_in,
  input  wire logic        rst_b_in,
  input  wire logic        can_mode_in,
  input  wire logic [7:0]  rx_data_in,
  input  wire logic        rx_valid_in,
  input  wire logic        rx_break_in,
  output logic [7:0]       tx_data_out,
  output logic             tx_valid_out,
  input  wire logic        tx_ready_in,
  output logic             tx_oe_b_out,
  output logic             tx_last_out,
  output cmd_core_s        exec_cmd_out,
  output logic             exec_req_out,
  input  wire logic        exec_done_in,
  input  wire result_s     exec_result_in
);
  // ==========================================
  // Receive and reply state
  phase_e      phase_reg, phase_next;
  logic [3:0]  idx_reg, idx_next;
  logic [7:0]  sum_reg, sum_next;
  logic [7:0]  frame_reg [9];
  logic [7:0]  frame_next [9];
  logic        mine_reg, mine_next;
  logic [7:0]  status_reg, status_next;
  logic [31:0] rvalue_reg, rvalue_next;
  logic [3:0]  flen;
  logic [3:0]  core0;
  logic [7:0]  rbyte;
  logic [7:0]  buf_data;
  logic        buf_valid;
  logic        buf_ready;
  logic        push;
  logic        sent_last;

  assign flen  = can_mode_in ? `CMD_LEN_CAN : `CMD_LEN_SERIAL; // RQ5
  assign core0 = can_mode_in ? `CORE_OFS_CAN : `CORE_OFS_SERIAL; // RQ11

  always_comb begin
    exec_cmd_out.cmd   = frame_reg[core0]; // RQ6
    exec_cmd_out.typ   = frame_reg[core0 + 4'h1];
    exec_cmd_out.bank  = frame_reg[core0 + 4'h2];
    exec_cmd_out.value = {frame_reg[core0 + 4'h3], frame_reg[core0 + 4'h4],
                          frame_reg[core0 + 4'h5], frame_reg[core0 + 4'h6]}; // RQ4
  end

  // ==========================================
  // Reply byte selection
  always_comb begin
    rbyte = 8'h00;
    if (can_mode_in) begin
      case (idx_reg)
        4'h0: rbyte = status_reg;
        4'h1: rbyte = frame_reg[0];
        4'h2: rbyte = rvalue_reg[31:24];
        4'h3: rbyte = rvalue_reg[23:16];
        4'h4: rbyte = rvalue_reg[15:8];
        4'h5: rbyte = rvalue_reg[7:0];
        default: rbyte = 8'h00;
      endcase // RQ11
    end else begin
      case (idx_reg)
        4'h0: rbyte = REPLY_ADDR;
        4'h1: rbyte = MODULE_ADDR;
        4'h2: rbyte = status_reg;
        4'h3: rbyte = frame_reg[1];
        4'h4: rbyte = rvalue_reg[31:24];
        4'h5: rbyte = rvalue_reg[23:16];
        4'h6: rbyte = rvalue_reg[15:8];
        4'h7: rbyte = rvalue_reg[7:0];
        4'h8: rbyte = sum_reg; // RQ10
        default: rbyte = 8'h00;
      endcase // RQ9
    end
  end

  // ==========================================
  // Sequencer
  always_comb begin
    phase_next  = phase_reg;
    idx_next    = idx_reg;
    sum_next    = sum_reg;
    mine_next   = mine_reg;
    status_next = status_reg;
    rvalue_next = rvalue_reg;
    push        = 1'b0;
    for (int i = 0; i < 9; i++) begin
      frame_next[i] = frame_reg[i];
    end
    case (phase_reg)
      ST_IDLE, ST_RECV: begin
        if (rx_break_in) begin
          phase_next = ST_IDLE;
          idx_next   = 4'h0;
          sum_next   = 8'h00;
        end else if (rx_valid_in) begin
          frame_next[idx_reg] = rx_data_in;
          if (idx_reg == `CMD_ADDR_IDX) begin
            mine_next = can_mode_in || (rx_data_in == MODULE_ADDR);
          end
          if (!can_mode_in && idx_reg == `CMD_CKSUM_IDX) begin
            status_next = (rx_data_in == sum_reg) ? `ST_OK : `ST_BAD_CKSUM; // RQ7
          end else begin
            sum_next    = sum_reg + rx_data_in; // RQ7
            status_next = `ST_OK;
          end
          phase_next = ST_RECV;
          idx_next   = idx_reg + 4'h1;
          if (idx_reg == flen - 4'h1) begin
            idx_next = 4'h0;
            // Clear the running sum so a dropped frame cannot skew the next one
            sum_next = 8'h00; // RQ7
            // Frames for other nodes are dropped silently to keep the bus quiet
            phase_next = mine_next ? ST_EXEC : ST_IDLE; // RQ2
          end
        end
      end
      ST_EXEC: begin
        sum_next = 8'h00;
        if (status_reg == `ST_BAD_CKSUM) begin
          rvalue_next = 32'h0000_0000;
          phase_next  = ST_SEND; // RQ14
        end else if (exec_done_in) begin
          status_next = exec_result_in.status; // RQ12 RQ13
          rvalue_next = exec_result_in.value;
          phase_next  = ST_SEND;
        end
      end
      ST_SEND: begin
        push = 1'b1;
        if (buf_ready) begin
          sum_next = sum_reg + rbyte; // RQ10
          idx_next = idx_reg + 4'h1;
          if (idx_reg == (can_mode_in ? `RPL_LAST_CAN : `CMD_CKSUM_IDX)) begin
            idx_next   = 4'h0;
            phase_next = ST_DRAIN; // RQ8
          end
        end
      end
      ST_DRAIN: begin
        sum_next = 8'h00;
        if (!buf_valid) begin
          phase_next = ST_IDLE;
        end
      end
      default: phase_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      phase_reg  <= ST_IDLE;
      idx_reg    <= 4'h0;
      sum_reg    <= 8'h00;
      mine_reg   <= 1'b0;
      status_reg <= `ST_OK;
      rvalue_reg <= 32'h0000_0000;
      for (int i = 0; i < 9; i++) begin
        frame_reg[i] <= 8'h00;
      end
    end else begin
      phase_reg  <= phase_next;
      idx_reg    <= idx_next;
      sum_reg    <= sum_next;
      mine_reg   <= mine_next;
      status_reg <= status_next;
      rvalue_reg <= rvalue_next;
      for (int i = 0; i < 9; i++) begin
        frame_reg[i] <= frame_next[i];
      end
    end
  end

  // Executor is only asked for frames with a good checksum
  assign exec_req_out = (phase_reg == ST_EXEC) && (status_reg != `ST_BAD_CKSUM); // RQ14

  // ==========================================
  // Output buffer, lets the line stall without losing bytes
  byte_skid #(.WIDTH(8)) u_skid (
    .clk_in        (clk_in),
    .rst_b_in      (rst_b_in),
    .in_data_in    (rbyte),
    .in_valid_in   (push),
    .in_ready_out  (buf_ready),
    .out_data_out  (buf_data),
    .out_valid_out (buf_valid),
    .out_ready_in  (tx_ready_in)
  );

  assign tx_data_out  = buf_data;
  assign tx_valid_out = buf_valid;
  // Valid and ready together mean exactly one byte is left in the buffer
  assign sent_last    = (phase_reg == ST_DRAIN) && buf_valid && buf_ready;
  assign tx_last_out  = sent_last;
  // Driver is enabled only while reply bytes are in flight
  assign tx_oe_b_out  = !((phase_reg == ST_SEND) || (phase_reg == ST_DRAIN)); // RQ3

  // ==========================================
  // Checks
  a_tx_only_reply: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    tx_valid_out |-> !tx_oe_b_out) // RQ3
    else $error("byte sent with driver off");
  a_idle_no_tx: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    phase_reg == ST_IDLE |-> tx_oe_b_out && !tx_valid_out) // RQ2
    else $error("transmit without command");
  a_bad_sum_skip: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    phase_reg == ST_EXEC && status_reg == `ST_BAD_CKSUM |-> !exec_req_out ##1 phase_reg == ST_SEND) // RQ14
    else $error("bad checksum frame executed");
  a_reply_after_exec: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    phase_reg == ST_EXEC && exec_done_in |=> phase_reg == ST_SEND && status_reg == $past(exec_result_in.status)) // RQ12
    else $error("status not taken from executor");
  a_reply_one: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    $rose(phase_reg == ST_SEND) |-> ##[1:300] phase_reg == ST_DRAIN) // RQ8
    else $error("reply not completed");
  a_send_sum: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    phase_reg == ST_SEND && buf_ready && !can_mode_in && idx_reg == `CMD_CKSUM_IDX |->
      rbyte == 8'(REPLY_ADDR + MODULE_ADDR + status_reg + frame_reg[1] + rvalue_reg[31:24] +
                  rvalue_reg[23:16] + rvalue_reg[15:8] + rvalue_reg[7:0])) // RQ10
    else $error("reply checksum wrong");
  a_serial_addr: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    phase_reg == ST_SEND && !can_mode_in && idx_reg == 4'h1 |-> rbyte == MODULE_ADDR) // RQ9
    else $error("reply module address wrong");
  a_rx_len: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    $rose(phase_reg == ST_EXEC) |-> $past(idx_reg) == flen - 4'h1) // RQ5
    else $error("frame length wrong");
  c_good_cmd: cover property (@(posedge clk_in) phase_reg == ST_EXEC && exec_done_in);
  c_bad_sum: cover property (@(posedge clk_in) phase_reg == ST_EXEC && status_reg == `ST_BAD_CKSUM);
  c_stall: cover property (@(posedge clk_in) tx_valid_out && !tx_ready_in);
  c_can: cover property (@(posedge clk_in) can_mode_in && phase_reg == ST_DRAIN);
endmodule

// [frame_pkg.sv]
// Types shared by the command frame handler and its testbench.
// Assumes frame_defs.svh is on the include path.
`include "frame_defs.svh"
package frame_pkg;
  // ==========================================
  // Decoded command core
  typedef struct packed {
    logic [7:0]  cmd;
    logic [7:0]  typ;
    logic [7:0]  bank;
    logic [31:0] value;
  } cmd_core_s;
  // ==========================================
  // Outcome from the command executor
  typedef struct packed {
    logic [7:0]  status;
    logic [31:0] value;
  } result_s;
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_RECV  = 3'b001,
    ST_EXEC  = 3'b010,
    ST_SEND  = 3'b011,
    ST_DRAIN = 3'b100
  } phase_e;
endpackage

// [host_model.sv]
// Host that sends command frames and collects reply bytes.
// Assumes the bench waits for each reply before the next send.
`timescale 1ns/1ns
module host_model (
  input  wire logic       clk_in,
  input  wire logic [7:0] tx_data_in,
  input  wire logic       tx_valid_in,
  output logic [7:0]      rx_data_out,
  output logic            rx_valid_out,
  output logic            rx_break_out,
  output logic            tx_ready_out
);
  byte unsigned got[$];
  bit           slow;
  initial begin
    rx_data_out = 8'h00;
    rx_valid_out = 1'b0;
    rx_break_out = 1'b0;
    tx_ready_out = 1'b1;
    slow = 1'b0;
  end
  // ==========================================
  // Reply capture, with random stalls when slow
  always @(posedge clk_in) begin
    if (tx_valid_in === 1'b1 && tx_ready_out) got.push_back(tx_data_in);
    tx_ready_out <= #1 slow ? 1'($urandom) : 1'b1;
  end
  // ==========================================
  // One frame, bytes back to back; line shows inverse after release
  task automatic send(input byte unsigned f[$]);
    @(posedge clk_in);
    #1;
    foreach (f[i]) begin
      rx_data_out = f[i];
      rx_valid_out = 1'b1;
      @(posedge clk_in);
      #1;
    end
    rx_valid_out = 1'b0;
    rx_data_out = ~rx_data_out;
  endtask
  task automatic brk();
    @(posedge clk_in);
    #1 rx_break_out = 1'b1;
    @(posedge clk_in);
    #1 rx_break_out = 1'b0;
  endtask
endmodule
